// *** logic/smsc_pkg.sv ***
// package: command codes, register offsets, bit positions and layout of the monitoring handler
`default_nettype none
package smsc_pkg;
    // task-file commands
    localparam logic [7:0] CMD_MONITOR     = 8'hb0;
    localparam logic [7:0] CMD_STANDBY_A   = 8'he2;
    localparam logic [7:0] CMD_STANDBY_B   = 8'h96;
    // monitoring subcommands, carried in the feature register, and their sector count and sector number operands
    localparam logic [7:0] SUB_AUTOSAVE    = 8'hd2;
    localparam logic [7:0] SUB_ENABLE      = 8'hd8;
    localparam logic [7:0] SUB_DISABLE     = 8'hd9;
    localparam logic [7:0] SUB_OFFLINE     = 8'hd4;
    localparam logic [7:0] SUB_READ_DATA   = 8'hd0;
    localparam logic [7:0] AUTOSAVE_OFF    = 8'h00;
    localparam logic [7:0] AUTOSAVE_ON     = 8'hf1;
    localparam logic [7:0] SEL_FIRST       = 8'hca;
    localparam logic [7:0] SEL_LAST        = 8'hd1;
    // offline collection status codes
    localparam logic [7:0] COLL_NEVER      = 8'h00;
    localparam logic [7:0] COLL_DONE       = 8'h02;
    localparam logic [7:0] COLL_SUSP_HOST  = 8'h04;
    localparam logic [7:0] COLL_ABORT_HOST = 8'h05;
    localparam logic [7:0] COLL_ABORT_DEV  = 8'h06;
    // data structure layout
    localparam int unsigned SEL_DATA_LAST  = 361;
    localparam int unsigned STD_FIRST      = 362;
    localparam int unsigned COMMON_FIRST   = 386;
    localparam int unsigned CHECKSUM_BYTE  = 511;
    localparam int unsigned STRUCT_BYTES   = 512;
    // collection time per statistic, in cycles
    localparam int unsigned COLLECT_CYCLES = 64;
    // wishbone word offsets (byte addresses)
    localparam logic [7:0] ADR_FEATURE     = 8'h00;
    localparam logic [7:0] ADR_SECCNT      = 8'h04;
    localparam logic [7:0] ADR_SECNUM      = 8'h08;
    localparam logic [7:0] ADR_COMMAND     = 8'h0c;
    localparam logic [7:0] ADR_STATUS      = 8'h10;
    localparam logic [7:0] ADR_ERROR       = 8'h14;
    localparam logic [7:0] ADR_DATA        = 8'h18;
    localparam logic [7:0] ADR_CTRL        = 8'h1c;
    // status, error and control register bit positions
    localparam int unsigned ST_BUSY        = 7;
    localparam int unsigned ST_DRQ         = 3;
    localparam int unsigned ST_ERR         = 0;
    localparam int unsigned ER_ABORT       = 2;
    localparam int unsigned CTRL_AUTOSAVE  = 0;
    localparam int unsigned CTRL_MON_EN    = 1;
    localparam int unsigned CTRL_SLEEP     = 2;
    localparam int unsigned CTRL_DONE      = 3;
    typedef enum logic [1:0] {SMSC_IDLE, SMSC_COLLECT, SMSC_READOUT} smsc_state_t;
endpackage
`default_nettype wire

// *** logic/smsc_stat_if.sv ***
// interface: request and result between the command core and the statistics engine
`default_nettype none
interface smsc_stat_if;
    logic       start;
    logic [2:0] sel;
    logic       done;
    logic [8:0] addr;
    logic [7:0] rdata;
    modport core (output start, output sel, output addr, input done, input rdata);
    modport engine (input start, input sel, input addr, output done, output rdata);
endinterface
`default_nettype wire

// *** logic/smsc_nv_cell.sv ***
// non-volatile enable cell: holds monitoring state across power cycles
`default_nettype none
module smsc_nv_cell #(
    parameter logic INIT = 1'b0
) (
    input  wire logic mclk_i,
    input  wire logic wr_i,
    input  wire logic d_i,
    output logic      q_o
);
    // no reset: a real cell keeps its value through power loss; INIT models the factory state
    logic cell_reg = INIT;
    always_ff @(posedge mclk_i)
    begin
        if (wr_i)
        begin
            cell_reg <= d_i;
        end
    end
    assign q_o = cell_reg;
endmodule
`default_nettype wire

// *** logic/smsc_stat_engine.sv ***
// statistics engine: gathers block statistics and serves the 512-byte structure
`default_nettype none
module smsc_stat_engine (
    input  wire logic   mclk_i,
    input  wire logic   rst_n_i,
    input  wire logic   wear_tick_i,
    smsc_stat_if.engine st
);
    logic [15:0] counter_reg;
    logic [15:0] result_reg;
    logic [2:0]  sel_reg;
    logic [7:0]  coll_status_reg;
    logic [$clog2(smsc_pkg::COLLECT_CYCLES):0] wait_reg;
    logic        run_reg;
    logic [7:0]  byte_val;
    logic [7:0]  sum;
    logic [7:0]  common_reg;

    // background gathering continues whatever the monitoring state is
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            counter_reg <= 16'h0000;
        else if (wear_tick_i)
            counter_reg <= counter_reg + 16'h0001;
    end

    // common byte frozen once readout leaves byte 0, so byte 386 and the checksum agree
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            common_reg <= 8'h00;
        else if (st.addr == 9'h000)
            common_reg <= counter_reg[7:0];
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            run_reg         <= 1'b0;
            wait_reg        <= '0;
            result_reg      <= 16'h0000;
            sel_reg         <= 3'h0;
            coll_status_reg <= smsc_pkg::COLL_NEVER;
        end
        else if (st.start)
        begin
            run_reg  <= 1'b1;
            wait_reg <= '0;
            sel_reg  <= st.sel;
        end
        else if (run_reg)
        begin
            wait_reg <= wait_reg + 1'b1;
            if (wait_reg == ($bits(wait_reg))'(smsc_pkg::COLLECT_CYCLES - 1))
            begin
                run_reg         <= 1'b0;
                result_reg      <= counter_reg ^ {13'h0000, sel_reg};
                coll_status_reg <= smsc_pkg::COLL_DONE;
            end
        end
    end
    assign st.done = run_reg && (wait_reg == ($bits(wait_reg))'(smsc_pkg::COLLECT_CYCLES - 1));

    function automatic logic [7:0] struct_byte(input logic [8:0] a);
        if (a == 9'(smsc_pkg::STD_FIRST))
            struct_byte = coll_status_reg;
        else if (a == 9'h000)
            struct_byte = {5'h00, sel_reg};
        else if (a == 9'h001)
            struct_byte = result_reg[7:0];
        else if (a == 9'h002)
            struct_byte = result_reg[15:8];
        else if (a == 9'(smsc_pkg::COMMON_FIRST))
            struct_byte = common_reg;
        else
            struct_byte = 8'h00;
    endfunction

    // checksum: two's complement of the sum of the first 511 bytes; only five are nonzero
    always_comb
    begin
        sum = coll_status_reg + {5'h00, sel_reg} + result_reg[7:0] + result_reg[15:8] + common_reg;
        if (st.addr == 9'(smsc_pkg::CHECKSUM_BYTE))
            byte_val = 8'h00 - sum;
        else
            byte_val = struct_byte(st.addr);
    end
    assign st.rdata = byte_val;
endmodule
`default_nettype wire

// *** logic/smsc_cmd_top.sv ***
// command core: monitoring subcommands and standby over a wishbone task file
`default_nettype none
module smsc_cmd_top #(
    parameter logic NV_INIT = 1'b0
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        wear_tick_i,
    output logic             intrq_o,
    output logic             sleep_o
);
    smsc_stat_if st ();

    logic [7:0]  feature_reg;
    logic [7:0]  seccnt_reg;
    logic [7:0]  secnum_reg;
    logic        busy_status_bit;
    logic        drq_reg;
    logic        err_reg;
    logic        abort_reg;
    logic        autosave_reg;
    logic        sleep_reg;
    logic        intrq_reg;
    logic        done_evt_reg;
    logic        ack_reg;
    logic [31:0] rdat_reg;
    logic [8:0]  rd_ptr_reg;
    smsc_pkg::smsc_state_t state_reg;
    logic        mon_en;
    logic        nv_wr;
    logic        nv_d;
    logic        req;
    logic        wr_req;
    logic        rd_req;
    logic        cmd_wr;
    logic        stby_cmd;
    logic        data_rd;
    logic        start_pulse;
    logic [2:0]  sel_code;
    logic        accept;
    logic        abort_now;
    logic        sel_ok;
    logic [7:0]  status_byte;
    logic [7:0]  error_byte;
    logic [7:0]  ctrl_byte;

    smsc_nv_cell #(
        .INIT (NV_INIT)
    ) u_nv (
        .mclk_i (mclk_i),
        .wr_i   (nv_wr),
        .d_i    (nv_d),
        .q_o    (mon_en)
    );

    smsc_stat_engine u_eng (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .wear_tick_i (wear_tick_i),
        .st          (st.engine)
    );

    // single-cycle request; ack next cycle, dropped in the cycle after
    assign req    = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr_req = req && wb_we_i && wb_sel_i[0];
    assign rd_req = req && !wb_we_i;
    // commands are refused while the core is busy
    assign cmd_wr = wr_req && (wb_adr_i == smsc_pkg::ADR_COMMAND) && !busy_status_bit;
    assign data_rd = rd_req && (wb_adr_i == smsc_pkg::ADR_DATA) && (state_reg == smsc_pkg::SMSC_READOUT);
    // either standby opcode; like every command it is refused while busy
    assign stby_cmd = cmd_wr && ((wb_dat_i[7:0] == smsc_pkg::CMD_STANDBY_A)
                                 || (wb_dat_i[7:0] == smsc_pkg::CMD_STANDBY_B));

    assign sel_ok   = (secnum_reg >= smsc_pkg::SEL_FIRST) && (secnum_reg <= smsc_pkg::SEL_LAST);
    // offsets 0..7 name the statistics in table order
    assign sel_code = 3'(secnum_reg - smsc_pkg::SEL_FIRST);

    always_comb
    begin
        accept    = 1'b0;
        abort_now = 1'b0;
        nv_wr     = 1'b0;
        nv_d      = mon_en;
        start_pulse = 1'b0;
        if (cmd_wr && (wb_dat_i[7:0] == smsc_pkg::CMD_MONITOR))
        begin
            if (!mon_en && (feature_reg != smsc_pkg::SUB_ENABLE))
                abort_now = 1'b1;
            else
            begin
                unique case (feature_reg)
                    smsc_pkg::SUB_ENABLE:
                    begin
                        nv_wr  = !mon_en;
                        nv_d   = 1'b1;
                        accept = 1'b1;
                    end
                    smsc_pkg::SUB_DISABLE:
                    begin
                        nv_wr  = 1'b1;
                        nv_d   = 1'b0;
                        accept = 1'b1;
                    end
                    smsc_pkg::SUB_AUTOSAVE:
                    begin
                        accept    = (seccnt_reg == smsc_pkg::AUTOSAVE_OFF) || (seccnt_reg == smsc_pkg::AUTOSAVE_ON);
                        abort_now = !accept;
                    end
                    smsc_pkg::SUB_OFFLINE:
                    begin
                        start_pulse = sel_ok;
                        abort_now   = !sel_ok;
                    end
                    smsc_pkg::SUB_READ_DATA:
                    begin
                        accept = 1'b1;
                    end
                    default:
                    begin
                        abort_now = 1'b1;
                    end
                endcase
            end
        end
    end
    assign st.start = start_pulse;
    assign st.sel   = sel_code;
    assign st.addr  = rd_ptr_reg;

    // task-file registers
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            feature_reg <= 8'h00;
            seccnt_reg  <= 8'h00;
            secnum_reg  <= 8'h00;
        end
        else if (wr_req && !busy_status_bit)
        begin
            if (wb_adr_i == smsc_pkg::ADR_FEATURE)
                feature_reg <= wb_dat_i[7:0];
            if (wb_adr_i == smsc_pkg::ADR_SECCNT)
                seccnt_reg <= wb_dat_i[7:0];
            if (wb_adr_i == smsc_pkg::ADR_SECNUM)
                secnum_reg <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            autosave_reg <= 1'b0;
        else if (cmd_wr && accept && (feature_reg == smsc_pkg::SUB_AUTOSAVE)
                 && (wb_dat_i[7:0] == smsc_pkg::CMD_MONITOR))
            autosave_reg <= (seccnt_reg == smsc_pkg::AUTOSAVE_ON);
    end

    // command sequencer
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state_reg       <= smsc_pkg::SMSC_IDLE;
            busy_status_bit <= 1'b0;
            drq_reg         <= 1'b0;
            rd_ptr_reg      <= 9'h000;
            done_evt_reg    <= 1'b0;
        end
        else
        begin
            done_evt_reg <= 1'b0;
            unique case (state_reg)
                smsc_pkg::SMSC_IDLE:
                begin
                    busy_status_bit <= 1'b0;
                    if (start_pulse)
                    begin
                        busy_status_bit <= 1'b1;
                        state_reg       <= smsc_pkg::SMSC_COLLECT;
                    end
                    else if (cmd_wr && accept && (wb_dat_i[7:0] == smsc_pkg::CMD_MONITOR)
                             && (feature_reg == smsc_pkg::SUB_READ_DATA))
                    begin
                        drq_reg    <= 1'b1;
                        rd_ptr_reg <= 9'h000;
                        state_reg  <= smsc_pkg::SMSC_READOUT;
                    end
                    else if (stby_cmd)
                    begin
                        busy_status_bit <= 1'b1;
                        done_evt_reg    <= 1'b1;
                    end
                    else if (cmd_wr)
                        done_evt_reg <= 1'b1;
                end
                smsc_pkg::SMSC_COLLECT:
                begin
                    if (st.done)
                    begin
                        busy_status_bit <= 1'b0;
                        done_evt_reg    <= 1'b1;
                        state_reg       <= smsc_pkg::SMSC_IDLE;
                    end
                end
                smsc_pkg::SMSC_READOUT:
                begin
                    if (data_rd)
                    begin
                        rd_ptr_reg <= rd_ptr_reg + 9'h001;
                        if (rd_ptr_reg == 9'(smsc_pkg::CHECKSUM_BYTE))
                        begin
                            drq_reg      <= 1'b0;
                            done_evt_reg <= 1'b1;
                            state_reg    <= smsc_pkg::SMSC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // error flags refresh on every command written while not busy, aborted ones included
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            err_reg   <= 1'b0;
            abort_reg <= 1'b0;
        end
        else if (cmd_wr)
        begin
            err_reg   <= abort_now;
            abort_reg <= abort_now;
        end
    end

    // low-power state: busy only blinks for one cycle, so standby completes at once
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            sleep_reg <= 1'b0;
        else if (stby_cmd)
            sleep_reg <= 1'b1;
        else if (cmd_wr)
            sleep_reg <= 1'b0;
    end

    // completion interrupt; reading status clears it, a new completion wins
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            intrq_reg <= 1'b0;
        else if (done_evt_reg)
            intrq_reg <= 1'b1;
        else if (rd_req && (wb_adr_i == smsc_pkg::ADR_STATUS))
            intrq_reg <= 1'b0;
    end

    assign status_byte = {busy_status_bit, 1'b1, 2'b00, drq_reg, 2'b00, err_reg};
    assign error_byte  = {5'h00, abort_reg, 2'b00};
    assign ctrl_byte   = {4'h0, (state_reg == smsc_pkg::SMSC_IDLE), sleep_reg, mon_en, autosave_reg};

    // bus answer; unmapped addresses read zero and ignore writes
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= req;
            if (rd_req)
            begin
                unique case (wb_adr_i)
                    smsc_pkg::ADR_FEATURE: rdat_reg <= {24'h000000, feature_reg};
                    smsc_pkg::ADR_SECCNT:  rdat_reg <= {24'h000000, seccnt_reg};
                    smsc_pkg::ADR_SECNUM:  rdat_reg <= {24'h000000, secnum_reg};
                    smsc_pkg::ADR_STATUS:  rdat_reg <= {24'h000000, status_byte};
                    smsc_pkg::ADR_ERROR:   rdat_reg <= {24'h000000, error_byte};
                    smsc_pkg::ADR_DATA:    rdat_reg <= {24'h000000, drq_reg ? st.rdata : 8'h00};
                    smsc_pkg::ADR_CTRL:    rdat_reg <= {24'h000000, ctrl_byte};
                    default:               rdat_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign intrq_o  = intrq_reg;
    assign sleep_o  = sleep_reg;
endmodule
`default_nettype wire

// *** verif/smsc_cmd_top_chk.sv ***
// checker: bus answer, standby entry and wake relations at the command core ports
`default_nettype none
module smsc_cmd_chk (
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        intrq_o,
    input wire logic        sleep_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic take;
    logic cmd_wr;
    logic stby_wr;
    assign take    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cmd_wr  = take && wb_we_i && wb_sel_i[0] && wb_adr_i == smsc_pkg::ADR_COMMAND;
    assign stby_wr = cmd_wr && (wb_dat_i[7:0] == smsc_pkg::CMD_STANDBY_A || wb_dat_i[7:0] == smsc_pkg::CMD_STANDBY_B);
    sequence s_stby_req;
        stby_wr;
    endsequence
    sequence s_wake_req;
        sleep_o && cmd_wr && !stby_wr;
    endsequence
    property p_ack_take;
        take |=> wb_ack_o;
    endproperty
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_ack_cause;
        wb_ack_o |-> $past(take);
    endproperty
    property p_rd_upper;
        wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000;
    endproperty
    property p_stby;
        s_stby_req |-> ##[1:2] sleep_o;
    endproperty
    property p_sleep_src;
        $rose(sleep_o) |-> $past(stby_wr) || $past(stby_wr, 2);
    endproperty
    property p_sleep_irq;
        $rose(sleep_o) |-> ##[0:2] intrq_o;
    endproperty
    property p_wake;
        s_wake_req |-> ##[1:2] !sleep_o;
    endproperty
    a_ack_take: assert property (p_ack_take)
        else $error("request not answered one cycle after it was taken");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without a taken request");
    a_rd_upper: assert property (p_rd_upper)
        else $error("read data upper bits not zero");
    a_stby: assert property (p_stby)
        else $error("standby command did not enter low power");
    a_sleep_src: assert property (p_sleep_src)
        else $error("low power entered without a standby command");
    a_sleep_irq: assert property (p_sleep_irq)
        else $error("no interrupt after standby");
    a_wake: assert property (p_wake)
        else $error("further command did not leave low power");
endmodule
bind smsc_cmd_top smsc_cmd_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .intrq_o(intrq_o), .sleep_o(sleep_o));
`default_nettype wire

// *** verif/smsc_host_model.sv ***
// host model: classic wishbone master issuing task-file accesses
`default_nettype none
module smsc_host_model (
    input  wire logic        mclk_i,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h00000000;
    end
    // data inverted after release so the slave cannot lean on a stale value
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge mclk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= 4'hf;
        dat_o <= {24'h000000, wd};
        do
            @(posedge mclk_i);
        while (ack_i !== 1'b1);
        rd = dat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        dat_o <= ~dat_o;
    endtask
    task automatic cmd(input logic [7:0] f, input logic [7:0] c, input logic [7:0] n, input logic [7:0] op);
        logic [7:0] d;
        xfer(1'b1, smsc_pkg::ADR_FEATURE, f, d);
        xfer(1'b1, smsc_pkg::ADR_SECCNT, c, d);
        xfer(1'b1, smsc_pkg::ADR_SECNUM, n, d);
        xfer(1'b1, smsc_pkg::ADR_COMMAND, op, d);
    endtask
endmodule
`default_nettype wire

// *** verif/smsc_cmd_top_test.sv ***
// testbench: monitoring subcommands, offline collection, readout and standby
`default_nettype none
module smsc_cmd_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        tick = 1'b0;
    logic [2:0]  tick_cnt = 3'h0;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        intrq;
    logic        sleep;
    int          num_errors = 0;
    int          n_tests = 0;
    int          k;
    logic [7:0]  s;
    logic [7:0]  v;
    logic [7:0]  st0;
    logic [7:0]  st1;

    smsc_cmd_top u_dut (.mclk_i(mclk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wear_tick_i(tick), .intrq_o(intrq), .sleep_o(sleep));
    smsc_host_model u_host (.mclk_i(mclk), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    initial
    begin
        forever #20 mclk = ~mclk;
    end
    // wear events keep coming, reset or not
    always @(posedge mclk)
    begin
        tick_cnt <= tick_cnt + 3'h1;
        tick     <= (tick_cnt == 3'h0);
    end

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("unexpected %s: expected %h, seen %h", what, e, g);
            num_errors++;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        u_host.xfer(1'b0, a, 8'h00, d);
    endtask
    task automatic ctl(input int b, input logic e);
        logic [7:0] d;
        rd(smsc_pkg::ADR_CTRL, d);
        chk("control bit", {7'h00, e}, {7'h00, d[b]});
    endtask
    // first status read lands while a captive command is still busy
    task automatic run(input logic [7:0] f, input logic [7:0] c, input logic [7:0] n, output logic [7:0] a,
                       output logic [7:0] z);
        int i;
        u_host.cmd(f, c, n, smsc_pkg::CMD_MONITOR);
        rd(smsc_pkg::ADR_STATUS, a);
        z = a;
        for (i = 0; i < 100 && z[smsc_pkg::ST_BUSY] !== 1'b0; i++)
            rd(smsc_pkg::ADR_STATUS, z);
    endtask
    task automatic mon(input logic [7:0] f, input logic [7:0] c, input logic [7:0] n, input logic ab);
        logic [7:0] a;
        logic [7:0] z;
        run(f, c, n, a, z);
        chk("error bit", {7'h00, ab}, {7'h00, z[smsc_pkg::ST_ERR]});
        if (ab)
        begin
            rd(smsc_pkg::ADR_ERROR, a);
            chk("abort bit", 8'h01, {7'h00, a[smsc_pkg::ER_ABORT]});
        end
    endtask
    task automatic readout(input logic [7:0] code, input logic [7:0] idx);
        logic [7:0] d;
        logic [7:0] sum;
        logic [7:0] stat;
        logic [7:0] first;
        int i;
        mon(smsc_pkg::SUB_READ_DATA, 8'h00, 8'h00, 1'b0);
        sum = 8'h00;
        for (i = 0; i < smsc_pkg::STRUCT_BYTES; i++)
        begin
            rd(smsc_pkg::ADR_DATA, d);
            sum = sum + d;
            if (i == smsc_pkg::STD_FIRST)
                stat = d;
            if (i == 0)
                first = d;
        end
        chk("selector", idx, first);
        chk("collection status", code, stat);
        chk("checksum", 8'h00, sum);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        do_reset();
        ctl(smsc_pkg::CTRL_MON_EN, 1'b0);
        mon(smsc_pkg::SUB_OFFLINE, 8'h00, smsc_pkg::SEL_FIRST, 1'b1);
        mon(smsc_pkg::SUB_READ_DATA, 8'h00, 8'h00, 1'b1);
        mon(smsc_pkg::SUB_ENABLE, 8'h00, 8'h00, 1'b0);
        ctl(smsc_pkg::CTRL_MON_EN, 1'b1);
        mon(smsc_pkg::SUB_ENABLE, 8'h00, 8'h00, 1'b0);
        ctl(smsc_pkg::CTRL_MON_EN, 1'b1);
        run(smsc_pkg::SUB_AUTOSAVE, smsc_pkg::AUTOSAVE_ON, 8'h00, st0, st1);
        chk("autosave busy", 8'h00, {7'h00, st0[smsc_pkg::ST_BUSY]});
        ctl(smsc_pkg::CTRL_AUTOSAVE, 1'b1);
        mon(smsc_pkg::SUB_AUTOSAVE, smsc_pkg::AUTOSAVE_OFF, 8'h00, 1'b0);
        ctl(smsc_pkg::CTRL_AUTOSAVE, 1'b0);
        mon(smsc_pkg::SUB_AUTOSAVE, 8'h55, 8'h00, 1'b1);
        mon(8'h77, 8'h00, 8'h00, 1'b1);
        mon(smsc_pkg::SUB_OFFLINE, 8'h00, 8'hc9, 1'b1);
        mon(smsc_pkg::SUB_OFFLINE, 8'h00, 8'hd2, 1'b1);
        for (s = smsc_pkg::SEL_FIRST; s <= smsc_pkg::SEL_LAST; s++)
        begin
            run(smsc_pkg::SUB_OFFLINE, 8'h00, s, st0, st1);
            chk("offline busy", 8'h01, {7'h00, st0[smsc_pkg::ST_BUSY]});
            chk("offline idle", 8'h00, {7'h00, st1[smsc_pkg::ST_BUSY]});
            readout(smsc_pkg::COLL_DONE, s - smsc_pkg::SEL_FIRST);
        end
        do_reset();
        ctl(smsc_pkg::CTRL_MON_EN, 1'b1);
        readout(smsc_pkg::COLL_NEVER, 8'h00);
        mon(smsc_pkg::SUB_DISABLE, 8'h00, 8'h00, 1'b0);
        ctl(smsc_pkg::CTRL_MON_EN, 1'b0);
        mon(smsc_pkg::SUB_DISABLE, 8'h00, 8'h00, 1'b1);
        mon(smsc_pkg::SUB_ENABLE, 8'h00, 8'h00, 1'b0);
        for (k = 0; k < 2; k++)
        begin
            chk("interrupt idle", 8'h00, {7'h00, intrq});
            u_host.xfer(1'b1, smsc_pkg::ADR_COMMAND, k ? smsc_pkg::CMD_STANDBY_B : smsc_pkg::CMD_STANDBY_A, v);
            repeat (3) @(posedge mclk);
            #1;
            chk("sleep", 8'h01, {7'h00, sleep});
            chk("interrupt", 8'h01, {7'h00, intrq});
            rd(smsc_pkg::ADR_STATUS, v);
            chk("standby busy", 8'h00, {7'h00, v[smsc_pkg::ST_BUSY]});
            mon(smsc_pkg::SUB_ENABLE, 8'h00, 8'h00, 1'b0);
            chk("wake", 8'h00, {7'h00, sleep});
        end
        stop_test();
    end
    // nine readouts of 512 bytes at three cycles each, with ample margin
    initial
    begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
